// ===== logic/sct_key_sector_command_intake.sv
// key sector intake: takes a 512-byte command packet, decodes, answers
// assumes words arrive from the drive's log-write data path, same clock
`timescale 1ns/1ps
`include "key_sector_cfg.svh"

// What this block does
// - success answer: error 00h, status 50h
// - failure: error 04h, status 51h, extended status in count/LBA low
// - every previous register byte in the answer is reserved
// - the command packet is always exactly 256 words
// - action code is packet word 0; parameters start at byte 4
// - function code is packet word 1, meaning depends on action
// - decode write same, error recovery, features, data table, others
// - action 0001h long sector access is unsupported
// - command page write issues commands, data page moves data
// - undefined or unsupported action fails with status 0010h
// - any reset terminates an executing command without trace
// - a locked secured device fails every command
module sct_key_sector_command_intake (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic SOFT_RST_I,
	input wire key_sector_pkg::tf_in_s TF_I,
	input wire logic START_I,
	input wire logic WORD_VALID_I,
	input wire logic [15:0] WORD_I,
	input wire logic SEC_LOCKED_I,
	input wire logic EXEC_DONE_I,
	input wire logic EXEC_FAIL_I,
	input wire logic [15:0] EXEC_STATUS_I,
	input wire logic [15:0] EXEC_RESULT_I,
	input wire logic [15:0] EXEC_SECTORS_I,
	output logic WORD_READY_O,
	output logic EXEC_START_O,
	output key_sector_pkg::cmd_s CMD_O,
	output logic BUSY_O,
	output logic DONE_O,
	output key_sector_pkg::tf_out_s TF_O
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RECV,
		ST_EXEC
	} state_e;

	state_e state_q;
	logic [8:0] count_q;
	logic [15:0] action_q;
	logic [15:0] function_q;
	logic tf_bad_q;
	logic locked_q;
	logic page_ok;
	logic take_word;
	logic last_word;
	key_sector_pkg::action_e action_dec;
	logic supported;
	logic fail_now;
	logic [15:0] fail_code;

	////////////////////////////////////////////////////////////////////////
	// intake checks

	// command page write carries a command, data page belongs elsewhere
	assign page_ok = (TF_I.command == `KS_CMD_EXT) &&
		(TF_I.lba_low_cur == `KS_CMD_PAGE);
	assign take_word = (state_q == ST_RECV) && WORD_VALID_I;
	assign last_word = take_word && (count_q == `KS_WORDS - 9'h001);
	assign WORD_READY_O = (state_q == ST_RECV);

	key_sector_decode u_decode (
		.code_i(action_q),
		.action_o(action_dec)
	);

	// only the named actions run here; vendor range has no engine
	always_comb begin
		supported = 1'b0;
		unique case (action_dec)
			key_sector_pkg::ACT_WRITE_SAME,
			key_sector_pkg::ACT_ERR_RECOVERY,
			key_sector_pkg::ACT_FEATURES,
			key_sector_pkg::ACT_DATA_TABLE: supported = 1'b1;
			key_sector_pkg::ACT_RESERVED,
			key_sector_pkg::ACT_VENDOR,
			key_sector_pkg::ACT_UNSUPPORTED: supported = 1'b0;
		endcase
	end

	// lock wins over task-file and action checks
	always_comb begin
		fail_now = 1'b1;
		fail_code = `KS_ES_OK;
		if (locked_q) begin
			fail_code = `KS_ES_LOCKED;
		end else if (tf_bad_q) begin
			fail_code = `KS_ES_BAD_TF;
		end else if (!supported) begin
			fail_code = `KS_ES_BAD_ACTION;
		end else begin
			fail_now = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing

	// soft or link reset ends everything silently, like the hard reset
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_q <= ST_IDLE;
		end else if (SOFT_RST_I) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: if (START_I && page_ok) state_q <= ST_RECV;
				ST_RECV: if (last_word) state_q <= ST_EXEC;
				ST_EXEC: if (fail_now || EXEC_DONE_I) state_q <= ST_IDLE;
			endcase
		end
	end

	// word counter across the packet
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			count_q <= 9'h000;
		end else if (SOFT_RST_I || state_q == ST_IDLE) begin
			count_q <= 9'h000;
		end else if (take_word) begin
			count_q <= count_q + 9'h001;
		end
	end

	// capture codes; words past 1 are parameters for the engine
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			action_q <= 16'h0000;
			function_q <= 16'h0000;
		end else if (take_word && count_q == {1'b0, `KS_WORD_ACTION}) begin
			action_q <= WORD_I;
		end else if (take_word &&
			count_q == {1'b0, `KS_WORD_FUNCTION}) begin
			function_q <= WORD_I;
		end
	end

	// task-file and lock checks sampled when the command is issued
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tf_bad_q <= 1'b0;
			locked_q <= 1'b0;
		end else if (state_q == ST_IDLE && START_I) begin
			tf_bad_q <= (TF_I.count_cur != `KS_CNT_CUR) ||
				(TF_I.count_prev != `KS_ZERO) ||
				(TF_I.lba_mid_cur != `KS_ZERO) ||
				(TF_I.lba_mid_prev != `KS_ZERO);
			locked_q <= SEC_LOCKED_I;
		end
	end

	// codes reach the engine only once the whole packet is in
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CMD_O <= '0;
			EXEC_START_O <= 1'b0;
		end else begin
			EXEC_START_O <= 1'b0;
			if (state_q == ST_EXEC && !SOFT_RST_I && !fail_now &&
				!EXEC_DONE_I && !BUSY_O && !EXEC_START_O) begin
				CMD_O.action <= action_dec;
				CMD_O.action_code <= action_q;
				CMD_O.function_code <= function_q;
				EXEC_START_O <= 1'b1;
			end
		end
	end

	// engine busy from launch until it reports or a reset cuts it
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			BUSY_O <= 1'b0;
		end else if (SOFT_RST_I || EXEC_DONE_I) begin
			BUSY_O <= 1'b0;
		end else if (EXEC_START_O) begin
			BUSY_O <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answer task file

	// previous bytes left zero: reserved, no meaning
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			TF_O <= '0;
			DONE_O <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			if (state_q == ST_EXEC && !SOFT_RST_I) begin
				TF_O.count_prev <= `KS_ZERO;
				TF_O.lba_low_prev <= `KS_ZERO;
				TF_O.lba_mid_prev <= `KS_ZERO;
				TF_O.lba_high_prev <= `KS_ZERO;
				if (fail_now || (EXEC_DONE_I && EXEC_FAIL_I)) begin
					DONE_O <= 1'b1;
					TF_O.error <= `KS_ERR_FAIL;
					TF_O.status <= `KS_STAT_FAIL;
					TF_O.count <= fail_now ? fail_code[7:0] :
						EXEC_STATUS_I[7:0];
					TF_O.lba_low <= fail_now ? fail_code[15:8] :
						EXEC_STATUS_I[15:8];
					TF_O.lba_mid <= fail_now ? `KS_ZERO :
						EXEC_SECTORS_I[7:0];
					TF_O.lba_high <= fail_now ? `KS_ZERO :
						EXEC_SECTORS_I[15:8];
				end else if (EXEC_DONE_I) begin
					DONE_O <= 1'b1;
					TF_O.error <= `KS_ERR_OK;
					TF_O.status <= `KS_STAT_OK;
					TF_O.count <= EXEC_RESULT_I[7:0];
					TF_O.lba_low <= EXEC_RESULT_I[15:8];
					TF_O.lba_mid <= EXEC_SECTORS_I[7:0];
					TF_O.lba_high <= EXEC_SECTORS_I[15:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	a_fail_answer: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state_q == ST_EXEC && !SOFT_RST_I && fail_now) |=>
			DONE_O && TF_O.status == `KS_STAT_FAIL &&
			TF_O.error == `KS_ERR_FAIL &&
			{TF_O.lba_low, TF_O.count} == $past(fail_code))
		else $error("failure answer wrong");

	a_ok_answer: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		(DONE_O && TF_O.error == `KS_ERR_OK) |->
			TF_O.status == `KS_STAT_OK)
		else $error("success status wrong");

	a_prev_reserved: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		DONE_O |-> TF_O.count_prev == `KS_ZERO &&
			TF_O.lba_high_prev == `KS_ZERO)
		else $error("previous byte not zero");

	a_full_packet: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state_q == ST_RECV && $past(state_q) == ST_IDLE) |->
			count_q == 9'h000)
		else $error("packet count not restarted");

	a_start_after_pkt: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		EXEC_START_O |-> $past(state_q) == ST_EXEC &&
			CMD_O.action_code == $past(action_q))
		else $error("engine launched early");

	a_bad_action: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state_q == ST_EXEC && !locked_q && !tf_bad_q &&
			action_q == `KS_AC_LONG) |-> fail_code == `KS_ES_BAD_ACTION)
		else $error("long access not refused");

	a_locked_fail: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state_q == ST_EXEC && locked_q && !SOFT_RST_I) |->
			fail_code == `KS_ES_LOCKED ##1 !EXEC_START_O && DONE_O)
		else $error("locked command not failed");

	a_single_launch: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		EXEC_START_O |=> !EXEC_START_O)
		else $error("engine launched twice");

	a_reset_ends: assert property (
		@(posedge CLK_I) disable iff (!RST_B_I)
		SOFT_RST_I |=> state_q == ST_IDLE && !BUSY_O && !DONE_O)
		else $error("reset did not end command");

endmodule : sct_key_sector_command_intake

// ===== shared/key_sector_cfg.svh
// constants for the key sector command intake: codes, counts, answers
// assumes inclusion by the design modules and the host model
`ifndef KEY_SECTOR_CFG_SVH
`define KEY_SECTOR_CFG_SVH

`define KS_WORDS 9'h100
`define KS_WORD_ACTION 8'h00
`define KS_WORD_FUNCTION 8'h01
`define KS_CMD_EXT 8'h3F
`define KS_CMD_PAGE 8'hE0
`define KS_DATA_PAGE 8'hE1
`define KS_CNT_CUR 8'h01
`define KS_ZERO 8'h00
`define KS_ERR_OK 8'h00
`define KS_ERR_FAIL 8'h04
`define KS_STAT_OK 8'h50
`define KS_STAT_FAIL 8'h51
`define KS_AC_RESERVED 16'h0000
`define KS_AC_LONG 16'h0001
`define KS_AC_WSAME 16'h0002
`define KS_AC_ERC 16'h0003
`define KS_AC_FEAT 16'h0004
`define KS_AC_TABLE 16'h0005
`define KS_AC_VENDOR 16'hC000
`define KS_ES_OK 16'h0000
`define KS_ES_BAD_ACTION 16'h0010
`define KS_ES_LOCKED 16'h0012
`define KS_ES_BAD_TF 16'h0003

`endif

// ===== shared/key_sector_pkg.sv
// types for the key sector command intake
// assumes key_sector_cfg.svh holds every number
package key_sector_pkg;

	// decoded command class
	typedef enum logic [2:0] {
		ACT_RESERVED,
		ACT_WRITE_SAME,
		ACT_ERR_RECOVERY,
		ACT_FEATURES,
		ACT_DATA_TABLE,
		ACT_VENDOR,
		ACT_UNSUPPORTED
	} action_e;

	// task-file values as written by the host
	typedef struct packed {
		logic [7:0] feature_cur;
		logic [7:0] feature_prev;
		logic [7:0] count_cur;
		logic [7:0] count_prev;
		logic [7:0] lba_low_cur;
		logic [7:0] lba_low_prev;
		logic [7:0] lba_mid_cur;
		logic [7:0] lba_mid_prev;
		logic [7:0] lba_high_cur;
		logic [7:0] lba_high_prev;
		logic [7:0] command;
	} tf_in_s;

	// task-file values returned to the host
	typedef struct packed {
		logic [7:0] error;
		logic [7:0] status;
		logic [7:0] count;
		logic [7:0] lba_low;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
		logic [7:0] count_prev;
		logic [7:0] lba_low_prev;
		logic [7:0] lba_mid_prev;
		logic [7:0] lba_high_prev;
	} tf_out_s;

	// latched command handed to the execution engine
	typedef struct packed {
		action_e action;
		logic [15:0] action_code;
		logic [15:0] function_code;
	} cmd_s;

endpackage : key_sector_pkg

// ===== logic/key_sector_decode.sv
// action code classifier for the key sector command intake
// assumes a 16-bit action code word; pure combinational
`timescale 1ns/1ps
`include "key_sector_cfg.svh"

module key_sector_decode (
	input wire logic [15:0] code_i,
	output key_sector_pkg::action_e action_o
);

	// map the action word onto a command class
	always_comb begin
		if (code_i >= `KS_AC_VENDOR) begin
			action_o = key_sector_pkg::ACT_VENDOR;
		end else begin
			unique case (code_i)
				`KS_AC_LONG: action_o = key_sector_pkg::ACT_UNSUPPORTED;
				`KS_AC_WSAME: action_o = key_sector_pkg::ACT_WRITE_SAME;
				`KS_AC_ERC: action_o = key_sector_pkg::ACT_ERR_RECOVERY;
				`KS_AC_FEAT: action_o = key_sector_pkg::ACT_FEATURES;
				`KS_AC_TABLE: action_o = key_sector_pkg::ACT_DATA_TABLE;
				default: action_o = key_sector_pkg::ACT_RESERVED;
			endcase
		end
	end

endmodule : key_sector_decode

// ===== tb/ks_host_model.sv
// host model: issues key sector packets into the intake's word port
// assumes issue() is called just after a rising clock edge
`timescale 1ns/1ps
`include "key_sector_cfg.svh"

module ks_host_model (
	input wire logic clk_i,
	input wire logic ready_i,
	output logic start_o,
	output key_sector_pkg::tf_in_s tf_o,
	output logic valid_o,
	output logic [15:0] word_o,
	output logic stall_o
);
	// idle levels at time zero
	initial begin
		stall_o = 1'b0;
		start_o = 1'b0;
		valid_o = 1'b0;
		word_o = 16'h0000;
		tf_o = '0;
	end

	////////////////////////////////////////////////////////////////////
	// one log write, then n words, each held until the intake takes it
	task automatic issue(input logic [15:0] act, fn,
		input logic [7:0] cnt_prev, page, input int n);
		int t;
		tf_o = '0;
		tf_o.command = `KS_CMD_EXT;
		tf_o.count_cur = 8'h01;
		tf_o.count_prev = cnt_prev;
		tf_o.lba_low_cur = page;
		start_o = 1'b1;
		@(posedge clk_i);
		#1 start_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			t = 0;
			// bounded: a stuck intake must not hang the host
			while (ready_i !== 1'b1 && t < 20) begin
				@(posedge clk_i);
				#1 t++;
			end
			// out of patience: flag it so the bench fails the run
			if (t >= 20) begin
				stall_o = 1'b1;
			end
			valid_o = 1'b1;
			word_o = i == 0 ? act : i == 1 ? fn : 16'(i * 257);
			@(posedge clk_i);
			#1;
		end
		// released line shows the inverse, never the last word
		valid_o = 1'b0;
		word_o = ~word_o;
	endtask : issue
endmodule : ks_host_model

// ===== tb/tb_top.sv
// self-checking bench for the key sector command intake
// assumes the host model feeds packets; engine replies come from here
`timescale 1ns/1ps

module tb_top;
	logic CLK_I, RST_B_I, SOFT_RST_I, START_I, WORD_VALID_I, SEC_LOCKED_I;
	logic EXEC_DONE_I, EXEC_FAIL_I, WORD_READY_O, EXEC_START_O;
	logic BUSY_O, DONE_O;
	logic [15:0] WORD_I, EXEC_STATUS_I, EXEC_RESULT_I, EXEC_SECTORS_I;
	key_sector_pkg::tf_in_s TF_I;
	key_sector_pkg::cmd_s CMD_O;
	key_sector_pkg::tf_out_s TF_O;
	int err_count = 0;
	int n_compared = 0;
	logic host_stall;
	typedef struct {
		logic [15:0] act;
		key_sector_pkg::action_e cls;
		logic early;
		logic ef;
	} row_s;
	row_s rows[11];

	sct_key_sector_command_intake dut (
		.CLK_I(CLK_I),
		.RST_B_I(RST_B_I),
		.SOFT_RST_I(SOFT_RST_I),
		.TF_I(TF_I),
		.START_I(START_I),
		.WORD_VALID_I(WORD_VALID_I),
		.WORD_I(WORD_I),
		.SEC_LOCKED_I(SEC_LOCKED_I),
		.EXEC_DONE_I(EXEC_DONE_I),
		.EXEC_FAIL_I(EXEC_FAIL_I),
		.EXEC_STATUS_I(EXEC_STATUS_I),
		.EXEC_RESULT_I(EXEC_RESULT_I),
		.EXEC_SECTORS_I(EXEC_SECTORS_I),
		.WORD_READY_O(WORD_READY_O),
		.EXEC_START_O(EXEC_START_O),
		.CMD_O(CMD_O),
		.BUSY_O(BUSY_O),
		.DONE_O(DONE_O),
		.TF_O(TF_O)
	);
	ks_host_model host (
		.clk_i(CLK_I),
		.ready_i(WORD_READY_O),
		.start_o(START_I),
		.tf_o(TF_I),
		.valid_o(WORD_VALID_I),
		.word_o(WORD_I),
		.stall_o(host_stall)
	);

	// a host that gave up waiting for ready ends the run as a failure
	always @(posedge CLK_I) begin
		if (host_stall === 1'b1) begin
			err_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	// verdict and compares
	task automatic complete_run();
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic note(input logic bad, input logic [79:0] g, e);
		n_compared++;
		if (bad) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : note

	task automatic chk_tf(input key_sector_pkg::tf_out_s g, e);
		note(g !== e, g, e);
	endtask : chk_tf

	task automatic chk_cmd(input key_sector_pkg::cmd_s g, e);
		note(g !== e, 80'(g), 80'(e));
	endtask : chk_cmd

	task automatic chk_bit(input logic g, e);
		note(g !== e, 80'(g), 80'(e));
	endtask : chk_bit

	// launch or answer, whichever comes first, within 30 cycles
	task automatic wait_out();
		int n;
		n = 0;
		while (EXEC_START_O !== 1'b1 && DONE_O !== 1'b1) begin
			@(posedge CLK_I);
			#1 n++;
			if (n > 30) begin
				err_count++;
				complete_run();
			end
		end
	endtask : wait_out

	// one full command; the bench answers in place of the engine
	task automatic run(input logic [15:0] act,
		input key_sector_pkg::action_e cls, input logic early, ef,
		input logic [7:0] cp, input logic [15:0] es);
		key_sector_pkg::tf_out_s e;
		logic [15:0] v;
		host.issue(act, ~act, cp, 8'hE0, 256);
		wait_out();
		chk_bit(EXEC_START_O, !early);
		EXEC_FAIL_I = ef;
		EXEC_RESULT_I = act ^ 16'h0F0F;
		EXEC_SECTORS_I = ~act;
		if (EXEC_START_O === 1'b1) begin
			chk_cmd(CMD_O, '{cls, act, ~act});
			EXEC_DONE_I = 1'b1;
			@(posedge CLK_I);
			#1 EXEC_DONE_I = 1'b0;
			wait_out();
		end
		v = early ? es : ef ? EXEC_STATUS_I : EXEC_RESULT_I;
		e = '0;
		e.error = (early | ef) ? 8'h04 : 8'h00;
		e.status = (early | ef) ? 8'h51 : 8'h50;
		{e.lba_low, e.count} = v;
		{e.lba_high, e.lba_mid} = early ? 16'h0000 : EXEC_SECTORS_I;
		chk_tf(TF_O, e);
	endtask : run

	////////////////////////////////////////////////////////////////////
	// 20 ns clock
	initial begin
		CLK_I = 1'b0;
		forever #10 CLK_I = ~CLK_I;
	end

	// table of codes, then hand-written awkward cases
	initial begin
		rows = '{'{16'h0002, key_sector_pkg::ACT_WRITE_SAME, 1'b0, 1'b0},
			'{16'h0003, key_sector_pkg::ACT_ERR_RECOVERY, 1'b0, 1'b0},
			'{16'h0004, key_sector_pkg::ACT_FEATURES, 1'b0, 1'b0},
			'{16'h0005, key_sector_pkg::ACT_DATA_TABLE, 1'b0, 1'b0},
			'{16'h0003, key_sector_pkg::ACT_ERR_RECOVERY, 1'b0, 1'b1},
			'{16'h0000, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0},
			'{16'h0001, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0},
			'{16'h0006, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0},
			'{16'hBFFF, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0},
			'{16'hC000, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0},
			'{16'hFFFF, key_sector_pkg::ACT_RESERVED, 1'b1, 1'b0}};
		RST_B_I = 1'b0;
		SOFT_RST_I = 1'b0;
		SEC_LOCKED_I = 1'b0;
		EXEC_DONE_I = 1'b0;
		EXEC_FAIL_I = 1'b0;
		EXEC_STATUS_I = 16'h0004;
		EXEC_RESULT_I = 16'h0000;
		EXEC_SECTORS_I = 16'h0000;
		repeat (5) @(posedge CLK_I);
		#1 RST_B_I = 1'b1;
		chk_tf(TF_O, '0);
		foreach (rows[i]) begin
			run(rows[i].act, rows[i].cls, rows[i].early, rows[i].ef,
				8'h00, 16'h0010);
		end
		// locked security fails even a good action
		SEC_LOCKED_I = 1'b1;
		run(16'h0002, key_sector_pkg::ACT_RESERVED, 1, 0, 8'h00,
			16'h0012);
		SEC_LOCKED_I = 1'b0;
		// previous count not zero
		run(16'h0004, key_sector_pkg::ACT_RESERVED, 1, 0, 8'h01,
			16'h0003);
		// data page write is not a command
		host.issue(16'h0002, 16'h0000, 8'h00, 8'hE1, 0);
		@(posedge CLK_I);
		#1 chk_bit(WORD_READY_O, 1'b0);
		// soft reset mid-packet, then mid-execution
		host.issue(16'h0002, 16'h0001, 8'h00, 8'hE0, 100);
		SOFT_RST_I = 1'b1;
		@(posedge CLK_I);
		#1 SOFT_RST_I = 1'b0;
		chk_bit(WORD_READY_O, 1'b0);
		host.issue(16'h0005, 16'h0001, 8'h00, 8'hE0, 256);
		wait_out();
		chk_bit(EXEC_START_O, 1'b1);
		@(posedge CLK_I);
		#1 chk_bit(BUSY_O, 1'b1);
		chk_bit(EXEC_START_O, 1'b0);
		SOFT_RST_I = 1'b1;
		@(posedge CLK_I);
		#1 SOFT_RST_I = 1'b0;
		repeat (4) begin
			@(posedge CLK_I);
			#1 chk_bit(DONE_O | BUSY_O, 1'b0);
		end
		// hard reset mid-execution clears every output at once
		host.issue(16'h0004, 16'h0002, 8'h00, 8'hE0, 256);
		wait_out();
		chk_bit(EXEC_START_O, 1'b1);
		RST_B_I = 1'b0;
		#1 chk_tf(TF_O, '0);
		chk_bit(BUSY_O | DONE_O | EXEC_START_O, 1'b0);
		@(posedge CLK_I);
		#1 RST_B_I = 1'b1;
		run(16'h0002, key_sector_pkg::ACT_WRITE_SAME, 0, 0, 8'h00,
			16'h0000);
		complete_run();
	end
endmodule : tb_top
